// ---- verilog/analog_config_lock_bank.sv ----
// Behaviour
// RULE1 - loopback bit routes comparator DAC to ADC A
// RULE2 - loopback overrides ADC A channel selection
// RULE3 - comparator control ignored unless master enable set
// RULE4 - control bit 0 frees low comparator DAC
// RULE5 - set lock bit blocks writes to protected register
// RULE6 - lock bits write-once, cleared only by reset
// RULE7 - lock bits 10, 9, 8 assignment
// RULE8 - lock bits 7, 6, 5 assignment
// RULE9 - lock bits 2, 1, 0; 4, 3 reserved
// RULE10 - pin enable bit switches analog pin function
// RULE11 - low enable bits 28,21,20,13,12 control pins
// RULE12 - high enable bits 18,6,4,3,2,0 control pins
// RULE13 - software sets pin enables once at init
// RULE14 - locked writes dropped silently, reads still work
`timescale 1ns/1ps
`include "analog_bank_consts.svh"

module analog_config_lock_bank #(
  parameter int                CHANNEL_WIDTH    = 5,
  parameter logic [7:0]        LOOPBACK_CHANNEL = 8'h00
) (
  // clock and resets
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       system_reset_n,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic                       hready,
  input  wire logic [31:0]                hwdata,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  // adc a input selection
  input  wire logic [CHANNEL_WIDTH-1:0]   adc_channel_select,
  output logic [CHANNEL_WIDTH-1:0]        adc_a_sample_channel,
  output logic                            dac_to_adc_a_loopback,
  // comparator 1 low side
  output logic                            low_comparator_enable,
  output logic                            comp1_low_dac_output_enable,
  // write locks for the analog registers kept elsewhere
  output logic                            voltage_regulator_control_lock,
  output logic                            low_negative_mux_select_lock,
  output logic                            high_negative_mux_select_lock,
  output logic                            low_positive_mux_select_lock,
  output logic                            high_positive_mux_select_lock,
  output logic                            voltage_monitor_control_lock,
  output logic                            analog_reference_control_lock,
  output logic                            temperature_sensor_control_lock,
  // analog function enables of the pins
  output logic [31:0]                     analog_capable_pin_enable_low,
  output logic [31:0]                     analog_capable_pin_enable_high
);

  // ----------------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------------
  if (CHANNEL_WIDTH < 1 || CHANNEL_WIDTH > `ADC_CHANNEL_MAX_WIDTH) begin : g_bad_width
    $error("channel width out of range");
  end
  if (int'(LOOPBACK_CHANNEL) >= (1 << CHANNEL_WIDTH)) begin : g_bad_channel
    $error("loopback channel does not fit channel width");
  end

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function automatic logic hit(input logic [`INDEX_WIDTH-1:0] index,
                               input logic [`INDEX_WIDTH-1:0] target);
    hit = (index == target);
  endfunction

  function automatic logic [`ADC_CHANNEL_MAX_WIDTH-1:0] widen_channel(
      input logic [CHANNEL_WIDTH-1:0] channel);
    logic [`ADC_CHANNEL_MAX_WIDTH-1:0] wide;
    wide = '0;
    wide[CHANNEL_WIDTH-1:0] = channel;
    widen_channel = wide;
  endfunction

  // ----------------------------------------------------------------------------
  // bus port
  // ----------------------------------------------------------------------------
  logic                      reg_write;
  logic [`INDEX_WIDTH-1:0]   reg_index;
  logic [31:0]               reg_wdata;
  logic [31:0]               reg_rdata;

  ahb_register_port u_ahb_register_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .reg_write (reg_write),
    .reg_index (reg_index),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata)
  );

  // ----------------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------------
  analog_bank_pkg::bank_state_type state;
  analog_bank_pkg::bank_state_type next_state;

  always_comb begin
    next_state = state;
    // lock bits only accumulate ones; a written zero changes nothing
    if (reg_write && hit(reg_index, `LOCK_INDEX)) begin
      next_state.lock = state.lock | reg_wdata[`LOCK_WIDTH-1:0]; // RULE6 RULE9
    end
    if (reg_write && hit(reg_index, `LOOPBACK_INDEX)) begin
      next_state.loopback = reg_wdata[`LOOPBACK_ADC_A_BIT]; // RULE1
    end
    // locked writes fall through with an okay answer
    if (reg_write && hit(reg_index, `CMP_CTL_INDEX)
        && !state.lock[`LOCK_CMP_CTL_BIT]) begin // RULE5 RULE7 RULE14
      next_state.cmp_master_en = reg_wdata[`CMP_MASTER_EN_BIT];
      next_state.cmp_ldac_out  = reg_wdata[`CMP_LDAC_OUT_BIT];
    end
    if (reg_write && hit(reg_index, `PIN_LOW_INDEX)) begin
      next_state.pin_low = reg_wdata; // RULE10
    end
    if (reg_write && hit(reg_index, `PIN_HIGH_INDEX)) begin
      next_state.pin_high = reg_wdata; // RULE10
    end
    // adc a sample channel is forced while loopback is on
    next_state.adc_channel = state.loopback ? LOOPBACK_CHANNEL
                                            : widen_channel(adc_channel_select); // RULE2
    // system reset clears comparator control and locks, not pin enables
    if (!system_reset_n) begin
      next_state.cmp_master_en = 1'b0; // RULE3
      next_state.cmp_ldac_out  = 1'b0;
      next_state.lock          = `LOCK_RESET; // RULE6
    end
  end

  // external pin reset clears everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  always_comb begin
    reg_rdata = 32'h0000_0000;
    case (reg_index)
      `LOOPBACK_INDEX: begin
        reg_rdata[`LOOPBACK_ADC_A_BIT] = state.loopback;
      end
      `CMP_CTL_INDEX: begin
        reg_rdata[`CMP_MASTER_EN_BIT] = state.cmp_master_en; // RULE14
        reg_rdata[`CMP_LDAC_OUT_BIT]  = state.cmp_ldac_out;
      end
      `LOCK_INDEX: begin
        reg_rdata[`LOCK_WIDTH-1:0] = state.lock;
      end
      `PIN_LOW_INDEX: begin
        reg_rdata = state.pin_low;
      end
      `PIN_HIGH_INDEX: begin
        reg_rdata = state.pin_high;
      end
      default: begin
        reg_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // analog controls
  // ----------------------------------------------------------------------------
  assign dac_to_adc_a_loopback = state.loopback; // RULE1
  assign adc_a_sample_channel  = state.adc_channel[CHANNEL_WIDTH-1:0]; // RULE2

  // control bit 0 counts only while the master enable is set
  assign comp1_low_dac_output_enable = state.cmp_master_en && state.cmp_ldac_out; // RULE3 RULE4
  assign low_comparator_enable       = !(state.cmp_master_en && state.cmp_ldac_out); // RULE4

  assign voltage_regulator_control_lock  = state.lock[`LOCK_VREG_BIT]; // RULE7
  assign low_negative_mux_select_lock    = state.lock[`LOCK_LOW_NEG_MUX_BIT]; // RULE7
  assign high_negative_mux_select_lock   = state.lock[`LOCK_HIGH_NEG_MUX_BIT]; // RULE8
  assign low_positive_mux_select_lock    = state.lock[`LOCK_LOW_POS_MUX_BIT]; // RULE8
  assign high_positive_mux_select_lock   = state.lock[`LOCK_HIGH_POS_MUX_BIT]; // RULE8
  assign voltage_monitor_control_lock    = state.lock[`LOCK_VMON_BIT]; // RULE9
  assign analog_reference_control_lock   = state.lock[`LOCK_REF_BIT]; // RULE9
  assign temperature_sensor_control_lock = state.lock[`LOCK_TSNS_BIT]; // RULE9

  // reserved enable bits are stored and read back but drive no pin
  assign analog_capable_pin_enable_low  = state.pin_low & `PIN_LOW_MASK; // RULE11
  assign analog_capable_pin_enable_high = state.pin_high & `PIN_HIGH_MASK; // RULE12

endmodule // analog_config_lock_bank

// ---- verilog/analog_bank_consts.svh ----
`ifndef ANALOG_BANK_CONSTS_SVH
`define ANALOG_BANK_CONSTS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define INDEX_WIDTH             9
`define LOOPBACK_INDEX          9'h088
`define CMP_CTL_INDEX           9'h08B
`define LOCK_INDEX              9'h08E
`define PIN_LOW_INDEX           9'h10A
`define PIN_HIGH_INDEX          9'h118

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define LOOPBACK_ADC_A_BIT      0
`define CMP_MASTER_EN_BIT       15
`define CMP_LDAC_OUT_BIT        0
`define LOCK_WIDTH              11
`define LOCK_CMP_CTL_BIT        10
`define LOCK_VREG_BIT           9
`define LOCK_LOW_NEG_MUX_BIT    8
`define LOCK_HIGH_NEG_MUX_BIT   7
`define LOCK_LOW_POS_MUX_BIT    6
`define LOCK_HIGH_POS_MUX_BIT   5
`define LOCK_VMON_BIT           2
`define LOCK_REF_BIT            1
`define LOCK_TSNS_BIT           0
`define PIN_LOW_MASK            32'h1030_3000
`define PIN_HIGH_MASK           32'h0004_005D

// ----------------------------------------------------------------------------
// reset values and bus codes
// ----------------------------------------------------------------------------
`define LOCK_RESET              11'h000
`define PIN_RESET               32'h0000_0000
`define DATA_WIDTH              32
`define HSIZE_WORD              3'h2
`define ADC_CHANNEL_MAX_WIDTH   8

`endif

// ---- verilog/analog_bank_pkg.sv ----
`include "analog_bank_consts.svh"

package analog_bank_pkg;

  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_WRITE,
    PORT_READ_WAIT,
    PORT_READ_DONE
  } port_phase_type;

  typedef struct packed {
    port_phase_type                 phase;
    logic [`INDEX_WIDTH-1:0]        index;
    logic                           write_ok;
    logic [`DATA_WIDTH-1:0]         hrdata;
  } port_state_type;

  typedef struct packed {
    logic                              loopback;
    logic                              cmp_master_en;
    logic                              cmp_ldac_out;
    logic [`LOCK_WIDTH-1:0]            lock;
    logic [`DATA_WIDTH-1:0]            pin_low;
    logic [`DATA_WIDTH-1:0]            pin_high;
    logic [`ADC_CHANNEL_MAX_WIDTH-1:0] adc_channel;
  } bank_state_type;

endpackage

// ---- verilog/ahb_register_port.sv ----
`timescale 1ns/1ps
`include "analog_bank_consts.svh"

module ahb_register_port (
  // clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic                          hready,
  input  wire logic [`DATA_WIDTH-1:0]        hwdata,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [`DATA_WIDTH-1:0]             hrdata,
  // register side
  output logic                               reg_write,
  output logic [`INDEX_WIDTH-1:0]            reg_index,
  output logic [`DATA_WIDTH-1:0]             reg_wdata,
  input  wire logic [`DATA_WIDTH-1:0]        reg_rdata
);

  analog_bank_pkg::port_state_type state;
  analog_bank_pkg::port_state_type next_state;
  logic                            take;

  // ----------------------------------------------------------------------------
  // phase tracking
  // ----------------------------------------------------------------------------
  // reads take one wait state so a write just before is already visible
  always_comb begin
    take = hsel && hready && htrans[1];
    next_state = state;
    case (state.phase)
      analog_bank_pkg::PORT_READ_WAIT: begin
        next_state.hrdata = reg_rdata;
        next_state.phase = analog_bank_pkg::PORT_READ_DONE;
      end
      default: begin
        next_state.phase = analog_bank_pkg::PORT_IDLE;
        if (take) begin
          next_state.index = haddr[`INDEX_WIDTH+1:2];
          next_state.write_ok = (hsize == `HSIZE_WORD);
          next_state.phase = hwrite ? analog_bank_pkg::PORT_WRITE
                                    : analog_bank_pkg::PORT_READ_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout = (state.phase != analog_bank_pkg::PORT_READ_WAIT);
  assign hresp     = 1'b0;
  assign hrdata    = state.hrdata;
  assign reg_write = (state.phase == analog_bank_pkg::PORT_WRITE) && state.write_ok;
  assign reg_index = state.index;
  assign reg_wdata = hwdata;

endmodule // ahb_register_port

// ---- sim/analog_config_lock_bank_asserts.sv ----
`timescale 1ns/1ps
`include "analog_bank_consts.svh"

module analog_config_lock_bank_asserts #(
  parameter int         CHANNEL_WIDTH    = 5,
  parameter logic [7:0] LOOPBACK_CHANNEL = 8'h00
) (
  // clock and resets
  input wire logic                     hclk,
  input wire logic                     hresetn,
  input wire logic                     system_reset_n,
  // bus
  input wire logic                     hsel,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic                     hready,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  // analog controls
  input wire logic [CHANNEL_WIDTH-1:0] adc_channel_select,
  input wire logic [CHANNEL_WIDTH-1:0] adc_a_sample_channel,
  input wire logic                     dac_to_adc_a_loopback,
  input wire logic                     comp1_low_dac_output_enable,
  input wire logic                     voltage_regulator_control_lock,
  input wire logic                     temperature_sensor_control_lock,
  input wire logic [31:0]              analog_capable_pin_enable_low
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [1:0] locks;
  assign locks = {voltage_regulator_control_lock, temperature_sensor_control_lock};

  sequence s_req(logic w);
    hsel && hready && htrans[1] && (hwrite == w);
  endsequence
  sequence s_read_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_loop_chan;
    dac_to_adc_a_loopback |=> adc_a_sample_channel == LOOPBACK_CHANNEL[CHANNEL_WIDTH-1:0];
  endproperty
  property p_chan_follow;
    hresetn && !dac_to_adc_a_loopback |=> adc_a_sample_channel == $past(adc_channel_select);
  endproperty
  property p_lock_hold;
    system_reset_n |=> (locks & $past(locks)) == $past(locks);
  endproperty
  property p_lock_clear;
    !system_reset_n |=> locks == 2'h0 && !comp1_low_dac_output_enable;
  endproperty
  property p_pin_mask;
    (analog_capable_pin_enable_low & ~`PIN_LOW_MASK) == 32'h0000_0000;
  endproperty
  property p_hresp;
    hresp == 1'b0;
  endproperty
  property p_read_wait;
    s_req(1'b0) |=> s_read_answer;
  endproperty
  property p_write_nowait;
    s_req(1'b1) |=> hreadyout;
  endproperty

  a_loop_chan: assert property (p_loop_chan) else $error("sample channel not loopback");
  a_chan_follow: assert property (p_chan_follow) else $error("sample channel wrong");
  a_lock_hold: assert property (p_lock_hold) else $error("lock bit cleared");
  a_lock_clear: assert property (p_lock_clear) else $error("system reset kept");
  a_pin_mask: assert property (p_pin_mask) else $error("reserved pin driven");
  a_hresp: assert property (p_hresp) else $error("error response");
  a_read_wait: assert property (p_read_wait) else $error("read answer timing");
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
endmodule // analog_config_lock_bank_asserts

bind analog_config_lock_bank analog_config_lock_bank_asserts #(
  .CHANNEL_WIDTH   (CHANNEL_WIDTH),
  .LOOPBACK_CHANNEL(LOOPBACK_CHANNEL)
) u_asserts (
  .hclk(hclk), .hresetn(hresetn), .system_reset_n(system_reset_n),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp),
  .adc_channel_select(adc_channel_select),
  .adc_a_sample_channel(adc_a_sample_channel),
  .dac_to_adc_a_loopback(dac_to_adc_a_loopback),
  .comp1_low_dac_output_enable(comp1_low_dac_output_enable),
  .voltage_regulator_control_lock(voltage_regulator_control_lock),
  .temperature_sensor_control_lock(temperature_sensor_control_lock),
  .analog_capable_pin_enable_low(analog_capable_pin_enable_low)
);

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`include "analog_bank_consts.svh"
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module tb;
  localparam logic [7:0]  LBC    = 8'h1E;
  localparam logic [31:0] A_LOOP = {21'h0, `LOOPBACK_INDEX, 2'b00};
  localparam logic [31:0] A_CMP  = {21'h0, `CMP_CTL_INDEX, 2'b00};
  localparam logic [31:0] A_LOCK = {21'h0, `LOCK_INDEX, 2'b00};
  localparam logic [31:0] A_PLO  = {21'h0, `PIN_LOW_INDEX, 2'b00};
  localparam logic [31:0] A_PHI  = {21'h0, `PIN_HIGH_INDEX, 2'b00};
  localparam logic [31:0] A_NONE = 32'h0000_0300;

  logic        hclk = 0, hresetn = 0, system_reset_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, acc, dummy, hrdata, pin_lo, pin_hi;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [4:0]  chan_sel = 0, sample_chan;
  wire  [7:0]  lk;
  logic        hreadyout, hresp, loop_on, low_comp, ldac;
  int          n_mismatch = 0, n_compared = 0, cycles = 0;
  logic [31:0] regs [5] = '{A_LOOP, A_CMP, A_LOCK, A_PLO, A_PHI};

  analog_config_lock_bank #(.CHANNEL_WIDTH(5), .LOOPBACK_CHANNEL(LBC)) u_analog_config_lock_bank (
    .hclk(hclk), .hresetn(hresetn), .system_reset_n(system_reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .adc_channel_select(chan_sel), .adc_a_sample_channel(sample_chan),
    .dac_to_adc_a_loopback(loop_on), .low_comparator_enable(low_comp),
    .comp1_low_dac_output_enable(ldac), .voltage_regulator_control_lock(lk[7]),
    .low_negative_mux_select_lock(lk[6]), .high_negative_mux_select_lock(lk[5]),
    .low_positive_mux_select_lock(lk[4]), .high_positive_mux_select_lock(lk[3]),
    .voltage_monitor_control_lock(lk[2]), .analog_reference_control_lock(lk[1]),
    .temperature_sensor_control_lock(lk[0]), .analog_capable_pin_enable_low(pin_lo),
    .analog_capable_pin_enable_high(pin_hi)
  );

  always #12.5 hclk = ~hclk;

  // ----------------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= `HSIZE_WORD;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, r);
    `CHK(nm, e, r)
  endtask

  task automatic summarize();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    system_reset_n <= 1'b1;
    foreach (regs[i]) rd_chk("reset value", regs[i], 32'h0000_0000);
    `CHK("low comparator", 1'b1, low_comp)
    wr(A_PLO, 32'hFFFF_FFFF);
    wr(A_PHI, 32'hFFFF_FFFF);
    `CHK("pins low", `PIN_LOW_MASK, pin_lo)
    `CHK("pins high", `PIN_HIGH_MASK, pin_hi)
    rd_chk("pins low rb", A_PLO, 32'hFFFF_FFFF);
    wr(A_PLO, 32'h1000_0000);
    wr(A_PHI, 32'h0000_0000);
    `CHK("pins low one", 32'h1000_0000, pin_lo)
    `CHK("pins high off", 32'h0000_0000, pin_hi)
    @(posedge hclk) chan_sel <= 5'h0B;
    wr(A_LOOP, 32'h0000_0001);
    `CHK("loopback", 1'b1, loop_on)
    repeat (2) @(negedge hclk);
    `CHK("forced channel", LBC[4:0], sample_chan)
    wr(A_LOOP, 32'h0000_0000);
    repeat (2) @(negedge hclk);
    `CHK("own channel", 5'h0B, sample_chan)
    wr(A_CMP, 32'h0000_0001);
    `CHK("dac out no master", 1'b0, ldac)
    rd_chk("cmp ctl rb", A_CMP, 32'h0000_0001);
    wr(A_CMP, 32'h0000_8001);
    `CHK("dac out", 1'b1, ldac)
    `CHK("low comp off", 1'b0, low_comp)
    acc = 32'h0000_0000;
    for (int b = 0; b < 11; b++) begin
      acc[b] = 1'b1;
      wr(A_LOCK, acc);
      `CHK("lock outputs", {acc[9:5], acc[2:0]}, lk)
    end
    wr(A_CMP, 32'h0000_8000);
    rd_chk("locked cmp ctl", A_CMP, 32'h0000_8001);
    `CHK("locked dac out", 1'b1, ldac)
    wr(A_LOCK, 32'h0000_0000);
    rd_chk("lock write once", A_LOCK, 32'h0000_07FF);
    wr(A_NONE, 32'hFFFF_FFFF);
    rd_chk("unmapped", A_NONE, 32'h0000_0000);
    @(posedge hclk) system_reset_n <= 1'b0;
    @(posedge hclk) system_reset_n <= 1'b1;
    rd_chk("lock after sysrst", A_LOCK, 32'h0000_0000);
    rd_chk("cmp after sysrst", A_CMP, 32'h0000_0000);
    rd_chk("pins after sysrst", A_PLO, 32'h1000_0000);
    // pin reset in mid-run clears loopback and pin enables
    wr(A_LOOP, 32'h0000_0001);
    @(posedge hclk) hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    `CHK("pins after pin reset", 32'h0000_0000, pin_lo)
    `CHK("loop after pin reset", 1'b0, loop_on)
    rd_chk("pins rb after pin reset", A_PLO, 32'h0000_0000);
    summarize();
  end
endmodule // tb
